//--- irq_ctrl_defs.vh
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// ==========================================================================
// Register offsets (8-bit index space of the plain register port)
`define ADDR_CTRL        8'h00
`define ADDR_ENABLE_LO   8'h01
`define ADDR_ENABLE_HI   8'h02
`define ADDR_PRIO_H_LO   8'h03
`define ADDR_PRIO_H_HI   8'h04
`define ADDR_PRIO_L_LO   8'h05
`define ADDR_PRIO_L_HI   8'h06
`define ADDR_FLAGS_A     8'h07
`define ADDR_FLAGS_B     8'h08
`define ADDR_FLAGS_C     8'h09
`define ADDR_STATUS      8'h0a

// ==========================================================================
// Control register fields
`define CTRL_GLOBAL_EN   7
`define CTRL_TRIG_LSB    0

// ==========================================================================
// Flag register A: external, timer 0/1, uart 0
`define FA_EXT0          0
`define FA_EXT1          1
`define FA_EXT2          2
`define FA_EXT3          3
`define FA_TMR0          4
`define FA_TMR1          5
`define FA_U0RX          6
`define FA_U0TX          7

// Flag register B: timer 2/3, spi, adc, uart 1
`define FB_T2OV          0
`define FB_T2EX          1
`define FB_T3OV          2
`define FB_T3EX          3
`define FB_SPI           4
`define FB_ADC           5
`define FB_U1RX          6
`define FB_U1TX          7

// Flag register C: counter array, system flags
`define FC_CA_OV         0
`define FC_CA_MOD_LSB    1
`define FC_BO0           7

// ==========================================================================
// Reset values
`define RST_CTRL         8'h00
`define RST_BYTE         8'h00

// Vector entry points
`define VEC_BASE         16'h0003
`define VEC_STEP         16'h0008
`define VEC_TIMER3       16'h0083

`endif

//--- irq_ctrl.v
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"

module irq_ctrl #(
   parameter integer NUM_SRC = 16,
   parameter integer SYNC_LEN = 3
) (
   input  wire        clk,
   input  wire        reset,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   // External interrupt pins, active low
   input  wire        ext_irq_pin_0_n,
   input  wire        ext_irq_pin_1_n,
   input  wire        ext_irq_pin_2_n,
   input  wire        ext_irq_pin_3_n,
   // Peripheral set pulses (same clock)
   input  wire        timer0_overflow_set,
   input  wire        timer1_overflow_set,
   input  wire        timer2_overflow_set,
   input  wire        timer2_external_set,
   input  wire        timer3_overflow_set,
   input  wire        timer3_external_set,
   input  wire        uart0_rx_set,
   input  wire        uart0_tx_set,
   input  wire        uart1_rx_set,
   input  wire        uart1_tx_set,
   input  wire        serial_periph_done_set,
   input  wire        converter_done_set,
   input  wire        counter_array_overflow_set,
   input  wire [5:0]  counter_array_module_set,
   input  wire        brownout0_set,
   input  wire        brownout1_set,
   input  wire        watchdog_overflow_set,
   input  wire        keypad_match_set,
   input  wire        two_wire_port_set,
   // CPU side
   input  wire        cpu_can_take,
   input  wire        cpu_return,
   output wire        irq_call,
   output reg  [15:0] irq_vector,
   output reg  [3:0]  irq_source,
   output reg  [1:0]  active_level,
   output reg         in_service
);

   // =======================================================================
   // Helpers
   // Level rank 3 highest; pair {high,low} used directly as rank
   function [15:0] vec_of;
      input [3:0] src;
      begin
         if (src == 4'hf)
            vec_of = `VEC_TIMER3;
         else
            vec_of = `VEC_BASE + {9'h000, src, 3'h0};
      end
   endfunction

   // =======================================================================
   // Control and configuration registers
   reg [7:0]  ctrl_q;
   reg [15:0] enable_q;
   reg [15:0] prio_h_q;
   reg [15:0] prio_l_q;
   wire       global_irq_enable = ctrl_q[`CTRL_GLOBAL_EN];
   wire [3:0] ext_trigger_type  = ctrl_q[`CTRL_TRIG_LSB +: 4];

   // Flag registers
   reg [7:0]  flags_a_q;
   reg [7:0]  flags_b_q;
   reg [7:0]  flags_c_q;
   reg        two_wire_flag_q;
   reg        brownout1_flag_q;
   reg        watchdog_flag_q;
   reg        keypad_flag_q;

   // =======================================================================
   // Pin synchronisers: three stages, change counts when last two agree
   wire [3:0] pins_n = {ext_irq_pin_3_n, ext_irq_pin_2_n,
                        ext_irq_pin_1_n, ext_irq_pin_0_n};
   reg  [3:0] s1_q;
   reg  [3:0] s2_q;
   reg  [3:0] s3_q;
   reg  [3:0] pin_n_q;
   reg  [3:0] pin_n_prev_q;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q         <= 4'hf;
         s2_q         <= 4'hf;
         s3_q         <= 4'hf;
         pin_n_q      <= 4'hf;
         pin_n_prev_q <= 4'hf;
      end else begin
         s1_q         <= pins_n;
         s2_q         <= s1_q;
         s3_q         <= s2_q;
         pin_n_q      <= (s2_q & s3_q) | (pin_n_q & (s2_q ^ s3_q));
         pin_n_prev_q <= pin_n_q;
      end
   end

   // Falling edge in transition mode, low level otherwise
   wire [3:0] ext_fall = pin_n_prev_q & ~pin_n_q;
   wire [3:0] ext_level = ~pin_n_q;

   // =======================================================================
   // Request formation
   wire [15:0] req;
   assign req[0]  = flags_a_q[`FA_EXT0];
   assign req[1]  = flags_a_q[`FA_TMR0];
   assign req[2]  = flags_a_q[`FA_EXT1];
   assign req[3]  = flags_a_q[`FA_TMR1];
   assign req[4]  = flags_a_q[`FA_U0RX] | flags_a_q[`FA_U0TX];
   assign req[5]  = flags_b_q[`FB_T2OV] | flags_b_q[`FB_T2EX];
   assign req[6]  = flags_a_q[`FA_EXT2];
   assign req[7]  = flags_a_q[`FA_EXT3];
   assign req[8]  = flags_b_q[`FB_SPI];
   assign req[9]  = flags_b_q[`FB_ADC];
   assign req[10] = |flags_c_q[6:0];
   assign req[11] = flags_c_q[`FC_BO0] | brownout1_flag_q | watchdog_flag_q;
   assign req[12] = flags_b_q[`FB_U1RX] | flags_b_q[`FB_U1TX];
   assign req[13] = keypad_flag_q;
   assign req[14] = two_wire_flag_q;
   assign req[15] = flags_b_q[`FB_T3OV] | flags_b_q[`FB_T3EX];

   // Sample stage: gated requests registered, polled next cycle
   reg [15:0] sample_q;
   always @(posedge clk or posedge reset) begin
      if (reset)
         sample_q <= 16'h0000;
      else
         sample_q <= req & enable_q & {16{global_irq_enable}};
   end

   // =======================================================================
   // Polling: highest level, then lowest source number
   reg [1:0] best_lvl;
   reg [3:0] best_src;
   reg       best_hit;
   integer   i;

   always @* begin
      best_lvl = 2'b00;
      best_src = 4'h0;
      best_hit = 1'b0;
      // Scan from lowest priority so the first source of a level wins
      for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
         if (sample_q[i] &&
             (!best_hit || {prio_h_q[i], prio_l_q[i]} >= best_lvl)) begin
            best_lvl = {prio_h_q[i], prio_l_q[i]};
            best_src = i[3:0];
            best_hit = 1'b1;
         end
      end
   end

   // =======================================================================
   // In-service stack, one bit per level; equal or higher blocks
   reg  [3:0] busy_q;
   reg  [1:0] top_lvl;
   reg        any_busy;
   integer    k;

   always @* begin
      top_lvl  = 2'b00;
      any_busy = 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
         if (busy_q[k]) begin
            top_lvl  = k[1:0];
            any_busy = 1'b1;
         end
      end
   end

   assign irq_call = best_hit && cpu_can_take &&
                     (!any_busy || best_lvl > top_lvl);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_q       <= 4'h0;
         irq_vector   <= 16'h0000;
         irq_source   <= 4'h0;
         active_level <= 2'b00;
         in_service   <= 1'b0;
      end else begin
         if (irq_call) begin
            busy_q[best_lvl] <= 1'b1;
            irq_vector       <= vec_of(best_src);
            irq_source       <= best_src;
            active_level     <= best_lvl;
            in_service       <= 1'b1;
         end else if (cpu_return && any_busy) begin
            busy_q[top_lvl] <= 1'b0;
            in_service      <= |(busy_q & ~(4'h1 << top_lvl));
         end
      end
   end

   // Vectoring clears, same cycle as the call
   wire       ack_ext0 = irq_call && best_src == 4'h0;
   wire       ack_tmr0 = irq_call && best_src == 4'h1;
   wire       ack_ext1 = irq_call && best_src == 4'h2;
   wire       ack_tmr1 = irq_call && best_src == 4'h3;
   wire       ack_ext2 = irq_call && best_src == 4'h6;
   wire       ack_ext3 = irq_call && best_src == 4'h7;
   wire [3:0] ack_ext  = {ack_ext3, ack_ext2, ack_ext1, ack_ext0};

   // =======================================================================
   // Register writes and flag updates; hardware set beats any clear
   wire wr_ctrl = reg_wr && reg_addr == `ADDR_CTRL;
   wire wr_fa   = reg_wr && reg_addr == `ADDR_FLAGS_A;
   wire wr_fb   = reg_wr && reg_addr == `ADDR_FLAGS_B;
   wire wr_fc   = reg_wr && reg_addr == `ADDR_FLAGS_C;
   wire wr_st   = reg_wr && reg_addr == `ADDR_STATUS;

   reg [7:0] fa_d;
   reg [7:0] fb_d;
   reg [7:0] fc_d;
   integer   e;

   always @* begin
      fa_d = wr_fa ? reg_wdata : flags_a_q;
      fb_d = wr_fb ? reg_wdata : flags_b_q;
      fc_d = wr_fc ? reg_wdata : flags_c_q;
      // Timer 0/1 self-clear on vectoring
      if (ack_tmr0) fa_d[`FA_TMR0] = 1'b0;
      if (ack_tmr1) fa_d[`FA_TMR1] = 1'b0;
      for (e = 0; e < 4; e = e + 1) begin
         if (ext_trigger_type[e]) begin
            if (ack_ext[e]) fa_d[e] = 1'b0;
            if (ext_fall[e]) fa_d[e] = 1'b1;
         end else begin
            // Level mode: flag follows the pin
            fa_d[e] = ext_level[e];
         end
      end
      if (timer0_overflow_set) fa_d[`FA_TMR0] = 1'b1;
      if (timer1_overflow_set) fa_d[`FA_TMR1] = 1'b1;
      if (uart0_rx_set)        fa_d[`FA_U0RX] = 1'b1;
      if (uart0_tx_set)        fa_d[`FA_U0TX] = 1'b1;
      if (timer2_overflow_set) fb_d[`FB_T2OV] = 1'b1;
      if (timer2_external_set) fb_d[`FB_T2EX] = 1'b1;
      if (timer3_overflow_set) fb_d[`FB_T3OV] = 1'b1;
      if (timer3_external_set) fb_d[`FB_T3EX] = 1'b1;
      if (serial_periph_done_set) fb_d[`FB_SPI] = 1'b1;
      if (converter_done_set)  fb_d[`FB_ADC]  = 1'b1;
      if (uart1_rx_set)        fb_d[`FB_U1RX] = 1'b1;
      if (uart1_tx_set)        fb_d[`FB_U1TX] = 1'b1;
      if (counter_array_overflow_set) fc_d[`FC_CA_OV] = 1'b1;
      fc_d[6:1] = fc_d[6:1] | counter_array_module_set;
      if (brownout0_set)       fc_d[`FC_BO0]  = 1'b1;
   end

   // Status register write holds the extra system/keypad/two-wire flags
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_q           <= `RST_CTRL;
         enable_q         <= 16'h0000;
         prio_h_q         <= 16'h0000;
         prio_l_q         <= 16'h0000;
         flags_a_q        <= `RST_BYTE;
         flags_b_q        <= `RST_BYTE;
         flags_c_q        <= `RST_BYTE;
         brownout1_flag_q <= 1'b0;
         watchdog_flag_q  <= 1'b0;
         keypad_flag_q    <= 1'b0;
         two_wire_flag_q  <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl_q <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_ENABLE_LO) enable_q[7:0]  <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_ENABLE_HI) enable_q[15:8] <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_PRIO_H_LO) prio_h_q[7:0]  <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_PRIO_H_HI) prio_h_q[15:8] <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_PRIO_L_LO) prio_l_q[7:0]  <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_PRIO_L_HI) prio_l_q[15:8] <= reg_wdata;
         flags_a_q <= fa_d;
         flags_b_q <= fb_d;
         flags_c_q <= fc_d;
         // Software write first, detector set overrides
         brownout1_flag_q <= brownout1_set | (wr_st ? reg_wdata[0] : brownout1_flag_q);
         watchdog_flag_q  <= watchdog_overflow_set |
                             (wr_st ? reg_wdata[1] : watchdog_flag_q);
         keypad_flag_q    <= keypad_match_set | (wr_st ? reg_wdata[2] : keypad_flag_q);
         two_wire_flag_q  <= two_wire_port_set |
                             (wr_st ? reg_wdata[3] : two_wire_flag_q);
      end
   end

   // =======================================================================
   // Read data, one cycle after the strobe; unmapped reads zero
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_CTRL:      reg_rdata <= ctrl_q;
            `ADDR_ENABLE_LO: reg_rdata <= enable_q[7:0];
            `ADDR_ENABLE_HI: reg_rdata <= enable_q[15:8];
            `ADDR_PRIO_H_LO: reg_rdata <= prio_h_q[7:0];
            `ADDR_PRIO_H_HI: reg_rdata <= prio_h_q[15:8];
            `ADDR_PRIO_L_LO: reg_rdata <= prio_l_q[7:0];
            `ADDR_PRIO_L_HI: reg_rdata <= prio_l_q[15:8];
            `ADDR_FLAGS_A:   reg_rdata <= flags_a_q;
            `ADDR_FLAGS_B:   reg_rdata <= flags_b_q;
            `ADDR_FLAGS_C:   reg_rdata <= flags_c_q;
            `ADDR_STATUS:    reg_rdata <= {in_service, active_level, 1'b0, two_wire_flag_q,
                                           keypad_flag_q, watchdog_flag_q, brownout1_flag_q};
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule // irq_ctrl

`default_nettype wire

//--- irq_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
// ======
// Port checker
module irq_ctrl_assertions (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        timer0_overflow_set,
   input wire logic        cpu_can_take,
   input wire logic        irq_call,
   input wire logic [15:0] irq_vector,
   input wire logic [3:0]  irq_source,
   input wire logic        in_service
);
   logic        glob_q;
   logic [15:0] en_q;
   logic [15:0] en_prev_q;

   // Shadow of the gating bits, so calls are judged from the ports alone
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         glob_q    <= 1'b0;
         en_q      <= 16'h0000;
         en_prev_q <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == `ADDR_CTRL) glob_q <= reg_wdata[`CTRL_GLOBAL_EN];
         if (reg_wr && reg_addr == `ADDR_ENABLE_LO) en_q[7:0] <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_ENABLE_HI) en_q[15:8] <= reg_wdata;
         en_prev_q <= en_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // ======
   // Sequences
   sequence s_call;
      irq_call ##1 in_service;
   endsequence
   // Call at c0 is excluded: it could leave the timer blocked by level
   sequence s_t0_ready;
      (timer0_overflow_set && glob_q && en_q[1] && !in_service && !irq_call) ##2 cpu_can_take;
   endsequence

   // ======
   // Properties
   a_vector_map: assert property (irq_call |=>
      irq_vector == ((irq_source == 4'hf) ? `VEC_TIMER3 : `VEC_BASE + {9'h000, irq_source, 3'h0}))
      else $error("vector does not match source");
   a_slot_unused: assert property (irq_call |=> irq_vector != 16'h007b)
      else $error("unused vector slot issued");
   a_global_gate: assert property (irq_call |-> glob_q)
      else $error("call with global enable off");
   a_source_enabled: assert property (irq_call |=> en_prev_q[irq_source])
      else $error("call from a disabled source");
   a_core_boundary: assert property (irq_call |-> cpu_can_take)
      else $error("call while core cannot take it");
   a_call_marks: assert property (irq_call |-> s_call)
      else $error("handler not marked active");
   a_poll_latency: assert property (s_t0_ready |-> irq_call)
      else $error("no call two cycles after timer set");
   a_unmapped_read: assert property (reg_rd && reg_addr > `ADDR_STATUS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // irq_ctrl_assertions
`default_nettype wire

//--- cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Core model: stalls on request, busy one cycle after each call
module cpu_core_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic irq_call,
   input  wire logic hold_off,
   input  wire logic ret_req,
   output logic      cpu_can_take,
   output logic      cpu_return
);
   logic busy_q;
   logic ret_q;

   // Call in flight blocks the next poll, as a real core would
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
         ret_q  <= 1'b0;
      end else begin
         busy_q <= irq_call;
         ret_q  <= ret_req;
      end
   end
   assign cpu_can_take = !hold_off && !busy_q;
   assign cpu_return   = ret_q;
endmodule // cpu_core_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   typedef struct packed {
      logic [4:0] idx;
      logic [3:0] src;
      logic [7:0] addr;
      logic [2:0] bitn;
      logic       clr;
   } row_t;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [3:0]  pins_n = 4'hf;
   logic [23:0] set_v = 24'h000000;
   logic        hold_off = 1'b0;
   logic        ret_req = 1'b0;
   logic [7:0]  reg_rdata, d;
   logic        cpu_can_take, cpu_return, irq_call, in_service;
   logic [15:0] irq_vector;
   logic [3:0]  irq_source;
   logic [1:0]  active_level;
   int          err_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   row_t        r;
   // One row per flag bit tested: stimulus, source, flag place, hardware clear
   row_t rows [24] = '{'{5'h18,4'h0,8'h07,3'h0,1'b1}, '{5'h00,4'h1,8'h07,3'h4,1'b1},
      '{5'h19,4'h2,8'h07,3'h1,1'b1}, '{5'h01,4'h3,8'h07,3'h5,1'b1},
      '{5'h06,4'h4,8'h07,3'h6,1'b0}, '{5'h07,4'h4,8'h07,3'h7,1'b0},
      '{5'h02,4'h5,8'h08,3'h0,1'b0}, '{5'h03,4'h5,8'h08,3'h1,1'b0},
      '{5'h1a,4'h6,8'h07,3'h2,1'b1}, '{5'h1b,4'h7,8'h07,3'h3,1'b1},
      '{5'h0a,4'h8,8'h08,3'h4,1'b0}, '{5'h0b,4'h9,8'h08,3'h5,1'b0},
      '{5'h0c,4'ha,8'h09,3'h0,1'b0}, '{5'h0d,4'ha,8'h09,3'h1,1'b0},
      '{5'h12,4'ha,8'h09,3'h6,1'b0}, '{5'h13,4'hb,8'h09,3'h7,1'b0},
      '{5'h14,4'hb,8'h0a,3'h0,1'b0}, '{5'h15,4'hb,8'h0a,3'h1,1'b0},
      '{5'h08,4'hc,8'h08,3'h6,1'b0}, '{5'h09,4'hc,8'h08,3'h7,1'b0},
      '{5'h16,4'hd,8'h0a,3'h2,1'b0}, '{5'h17,4'he,8'h0a,3'h3,1'b0},
      '{5'h04,4'hf,8'h08,3'h2,1'b0}, '{5'h05,4'hf,8'h08,3'h3,1'b0}};

   always #5 clk = ~clk;

   irq_ctrl uut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_irq_pin_0_n(pins_n[0]), .ext_irq_pin_1_n(pins_n[1]),
      .ext_irq_pin_2_n(pins_n[2]), .ext_irq_pin_3_n(pins_n[3]),
      .timer0_overflow_set(set_v[0]), .timer1_overflow_set(set_v[1]),
      .timer2_overflow_set(set_v[2]), .timer2_external_set(set_v[3]),
      .timer3_overflow_set(set_v[4]), .timer3_external_set(set_v[5]),
      .uart0_rx_set(set_v[6]), .uart0_tx_set(set_v[7]), .uart1_rx_set(set_v[8]),
      .uart1_tx_set(set_v[9]), .serial_periph_done_set(set_v[10]),
      .converter_done_set(set_v[11]), .counter_array_overflow_set(set_v[12]),
      .counter_array_module_set(set_v[18:13]), .brownout0_set(set_v[19]),
      .brownout1_set(set_v[20]), .watchdog_overflow_set(set_v[21]),
      .keypad_match_set(set_v[22]), .two_wire_port_set(set_v[23]),
      .cpu_can_take(cpu_can_take), .cpu_return(cpu_return), .irq_call(irq_call),
      .irq_vector(irq_vector), .irq_source(irq_source), .active_level(active_level),
      .in_service(in_service));
   cpu_core_model core (.clk(clk), .reset(reset), .irq_call(irq_call), .hold_off(hold_off),
      .ret_req(ret_req), .cpu_can_take(cpu_can_take), .cpu_return(cpu_return));

   // ======
   // Bus and handshake tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask
   // Pins are held two cycles so the three-stage filter sees them settle
   task automatic pulse(input logic [27:0] m);
      @(posedge clk);
      set_v <= m[23:0]; pins_n <= ~m[27:24];
      @(posedge clk);
      set_v <= 24'h000000;
      @(posedge clk);
      pins_n <= 4'hf;
   endtask
   task automatic ret;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask
   task automatic expect_call(input logic [3:0] s);
      logic [15:0] v;
      int k;
      v = (s == 4'hf) ? 16'h0083 : 16'h0003 + {9'h000, s, 3'h0};
      k = 0;
      @(negedge clk);
      while (irq_call !== 1'b1 && k < 30) begin
         @(negedge clk);
         k++;
      end
      `CHK(irq_call, 1'b1)
      @(negedge clk);
      `CHK(irq_source, s)
      `CHK(irq_vector, v)
   endtask
   task automatic quiet;
      logic seen;
      seen = 1'b0;
      repeat (20) begin
         @(negedge clk);
         seen = seen | irq_call;
      end
      `CHK(seen, 1'b0)
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard; the whole run needs well under a thousand cycles per row
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         conclude;
      end
   end

   // ======
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rd(8'h00, d);
      `CHK(d, 8'h00)
      rd(8'h02, d);
      `CHK(d, 8'h00)
      rd(8'h0b, d);
      `CHK(d, 8'h00)
      wr(8'h00, 8'h8f); wr(8'h01, 8'hff); wr(8'h02, 8'hff);
      foreach (rows[i]) begin
         r = rows[i];
         pulse(28'h1 << r.idx);
         expect_call(r.src);
         rd(r.addr, d);
         `CHK(d[r.bitn], ~r.clr)
         wr(r.addr, 8'h00);
         rd(r.addr, d);
         `CHK(d[r.bitn], 1'b0)
         ret;
      end
      // Gating by global and per-source enable, and by the core
      wr(8'h00, 8'h0f); pulse(28'h1); quiet;
      wr(8'h00, 8'h8f); expect_call(4'h1); ret;
      wr(8'h01, 8'hfd); pulse(28'h1); quiet;
      wr(8'h01, 8'hff); expect_call(4'h1); ret;
      @(posedge clk) hold_off <= 1'b1;
      pulse(28'h1); quiet;
      @(posedge clk) hold_off <= 1'b0;
      expect_call(4'h1); ret;
      wr(8'h08, 8'h10); expect_call(4'h8); wr(8'h08, 8'h00); ret;
      // Levels: timer 1 at 10 beats timer 0 at 01, timer 3 at 11 beats all
      wr(8'h03, 8'h08); wr(8'h05, 8'h02); wr(8'h04, 8'h80); wr(8'h06, 8'h80);
      pulse(28'h3); expect_call(4'h3); ret; expect_call(4'h1); ret;
      wr(8'h03, 8'h00); wr(8'h05, 8'h00);
      pulse(28'h11); expect_call(4'hf); pulse(28'h2); quiet;
      `CHK(active_level, 2'b11)
      wr(8'h08, 8'h00); ret; expect_call(4'h1); ret; expect_call(4'h3); ret;
      pulse(28'h1); expect_call(4'h1); pulse(28'h10); expect_call(4'hf);
      wr(8'h08, 8'h00); ret; ret;
      // Level mode: flag follows the pin and survives vectoring
      wr(8'h00, 8'h8e);
      @(posedge clk) pins_n <= 4'he;
      expect_call(4'h0); rd(8'h07, d);
      `CHK(d[0], 1'b1)
      @(posedge clk) pins_n <= 4'hf;
      repeat (8) @(posedge clk);
      rd(8'h07, d);
      `CHK(d[0], 1'b0)
      ret;
      // Mid-run reset: everything back to idle, global enable off again
      @(posedge clk) reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      `CHK(in_service, 1'b0)
      `CHK(irq_vector, 16'h0000)
      rd(8'h00, d);
      `CHK(d, 8'h00)
      pulse(28'h1); quiet;
      conclude;
   end
endmodule // testbench

bind irq_ctrl irq_ctrl_assertions chk (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_overflow_set(timer0_overflow_set),
   .cpu_can_take(cpu_can_take), .irq_call(irq_call), .irq_vector(irq_vector),
   .irq_source(irq_source), .in_service(in_service));
`default_nettype wire
